/* sms_core.sv */
// Purpose: Byte serial port, master or slave, with three select modes
// Assumes: Control bits arrive as plain ports; clock idles low, rising-edge sample
// Notes:   Slave shifting runs on the link clock in sms_slave_link
//
// How it works
// RL1: As master, output line follows shift register top bit, top bit first.
// RL2: Slave output floats when port disabled or 4-wire slave deselected.
// RL3: 3-wire slave always drives output from shift register top bit.
// RL4: Deselected 4-wire slave ignores the serial clock.
// RL5: Mode 00 is 3-wire, select unused, slave always selected.
// RL6: Mode 01 uses select pin as input choosing the slave.
// RL7: Master in mode 01 stops when select input falls.
// RL8: Upper mode bit set drives select pin with lower mode bit.
// RL9: Select routed to a pin except in 3-wire mode.
// RL10: Master enable bit picks master; clear with port enabled is slave.
// RL11: Master data write fills buffer; empty shifter loads and starts at once.
// RL12: Master makes serial clock, shifts out and in simultaneously.
// RL13: Complete flag set at every byte end; raises interrupt when enabled.
// RL14: Eight received bits copied to receive buffer, read back as data.
// RL15: Mode 01 reset default; low select on a master clears enables, sets mode fault.
// RL16: Mode fault raises interrupt when interrupts enabled.
// RL17: Software alone re-enables master and port after a mode fault.
// RL18: Write with full transmit buffer discarded, collision flag set.
// RL19: Status flags stay set until software clears them.
// RL20: Master bit rate at most half system clock and 12.5 MHz.
// RL21: Waiting byte starts the next master transfer automatically.
`timescale 1ns/1ps
`default_nettype none
module sms_core
  import sms_pkg::*;
#(
  parameter int unsigned SCK_HALF_CYCLES = 4
)(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic sck_link,
  input wire logic ctrl_wr,
  input wire sms_ctrl_t ctrl_in,
  input wire logic int_enable,
  input wire logic data_wr,
  input wire logic [7:0] data_in,
  input wire logic data_rd,
  input wire sms_flags_t flag_clr,
  output sms_ctrl_t ctrl_out,
  output sms_flags_t flags_out,
  output logic [7:0] rx_data,
  output logic tx_buf_full,
  output logic irq_req,
  output logic sck_out,
  output logic sck_oe,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic mosi_in,
  output logic miso_out,
  output logic miso_oe,
  input wire logic miso_in,
  input wire logic slave_select_n_in,
  output logic slave_select_n_out,
  output logic slave_select_n_oe,
  output logic select_routed
);

  // Never faster than the limit, whatever the parameter asks for [RL20]
  localparam int unsigned HALF_EFF = (SCK_HALF_CYCLES < MIN_HALF_CYCLES) ? MIN_HALF_CYCLES
                                                                          : SCK_HALF_CYCLES;

  // ****************************************
  // State
  // ****************************************
  sms_ctrl_t ctrl_reg, ctrl_next;
  sms_flags_t flags_reg, flags_next;
  sms_state_t state_reg, state_next;
  logic [7:0] tx_buf_reg, tx_buf_next;
  logic tx_full_reg, tx_full_next;
  logic [7:0] shift_reg, shift_next;
  logic samp_reg, samp_next;
  logic [2:0] bit_reg, bit_next;
  logic [7:0] div_reg, div_next;
  logic [7:0] rx_reg, rx_next;
  logic unread_reg, unread_next;
  logic irq_reg, irq_next;
  logic sck_reg, sck_next;
  logic mosi_reg, mosi_next;
  logic mosi_oe_reg, mosi_oe_next;
  logic sck_oe_reg, sck_oe_next;
  logic miso_oe_reg, miso_oe_next;
  logic ss_out_reg, ss_out_next;
  logic ss_oe_reg, ss_oe_next;
  logic routed_reg, routed_next;
  logic clr_reg, clr_next;
  logic req_reg, req_next;
  logic [7:0] slv_byte_reg, slv_byte_next;
  logic done_last_reg, done_last_next;
  logic ss_s1_reg, ss_s2_reg, miso_s1_reg, miso_s2_reg;
  logic done_s1_reg, done_s2_reg, ack_s1_reg, ack_s2_reg;
  logic master_on, slave_on, multi_mode, start, finishing;
  logic [7:0] shifted;
  logic slv_ack, slv_done, slv_miso;
  logic [7:0] slv_rx;

  // ****************************************
  // Slave link
  // ****************************************
  sms_slave_link i_sms_slave_link (
    .sck_link(sck_link),
    .link_clr(clr_reg),
    .mosi_in(mosi_in),
    .tx_req(req_reg),
    .tx_byte(slv_byte_reg),
    .tx_ack(slv_ack),
    .done_tgl(slv_done),
    .rx_byte(slv_rx),
    .miso_out(slv_miso)
  );

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    ctrl_next = ctrl_reg;
    flags_next = flags_reg & ~flag_clr;
    state_next = state_reg;
    tx_buf_next = tx_buf_reg;
    tx_full_next = tx_full_reg;
    shift_next = shift_reg;
    samp_next = samp_reg;
    bit_next = bit_reg;
    div_next = div_reg;
    rx_next = rx_reg;
    unread_next = unread_reg & ~data_rd;
    sck_next = 1'b0;
    req_next = req_reg;
    slv_byte_next = slv_byte_reg;
    done_last_next = done_last_reg;
    start = 1'b0;
    finishing = 1'b0;
    shifted = {shift_reg[6:0], samp_reg};
    master_on = ctrl_reg.master_enable_bit & ctrl_reg.port_enable_bit; // [RL10]
    slave_on = ~ctrl_reg.master_enable_bit & ctrl_reg.port_enable_bit; // [RL10]
    multi_mode = ctrl_reg.select_mode_field == MODE_MULTI;
    if (ctrl_wr) begin
      ctrl_next = ctrl_in;
    end
    // Master transfer, mode 0 timing
    unique case (state_reg)
      ST_IDLE: begin
        start = master_on & tx_full_reg; // [RL11]
      end
      ST_LOW: begin
        if (div_reg == 8'(HALF_EFF - 1)) begin
          div_next = 8'h00;
          sck_next = 1'b1; // [RL12]
          samp_next = miso_s2_reg;
          state_next = ST_HIGH;
        end else begin
          div_next = div_reg + 8'h01;
        end
      end
      ST_HIGH: begin
        sck_next = 1'b1;
        if (div_reg == 8'(HALF_EFF - 1)) begin
          div_next = 8'h00;
          sck_next = 1'b0;
          if (bit_reg == 3'(BYTE_BITS - 1)) begin
            finishing = 1'b1;
            flags_next.transfer_complete_flag = 1'b1; // [RL13]
            rx_next = shifted; // [RL14]
            unread_next = 1'b1;
            shift_next = shifted;
            state_next = ST_IDLE;
            start = tx_full_reg; // [RL21]
          end else begin
            shift_next = shifted; // [RL12]
            bit_next = bit_reg + 3'h1;
            state_next = ST_LOW;
          end
        end else begin
          div_next = div_reg + 8'h01;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (start) begin
      shift_next = tx_buf_reg; // [RL11]
      tx_full_next = 1'b0;
      bit_next = 3'h0;
      div_next = 8'h00;
      state_next = ST_LOW;
    end
    // Slave hand-off of the buffered byte to the link side
    if (slave_on && !clr_reg && tx_full_reg && req_reg == ack_s2_reg) begin
      slv_byte_next = tx_buf_reg;
      req_next = ~req_reg;
      tx_full_next = 1'b0;
    end
    if (clr_reg) begin
      req_next = 1'b0;
      done_last_next = 1'b0;
    end else if (done_s2_reg != done_last_reg) begin
      done_last_next = done_s2_reg;
      flags_next.transfer_complete_flag = 1'b1; // [RL13]
      // Overrun keeps the unread byte and drops the new one
      if (unread_reg && !data_rd) begin
        flags_next.receive_overrun_flag = 1'b1;
      end else begin
        rx_next = slv_rx; // [RL14]
        unread_next = 1'b1;
      end
    end
    // Writes: a full buffer refuses and flags it; set wins over clear [RL19]
    if (data_wr) begin
      if (tx_full_reg) begin
        flags_next.write_collision_flag = 1'b1; // [RL18]
      end else begin
        tx_buf_next = data_in;
        tx_full_next = 1'b1;
      end
    end
    // Another master pulled select low; hardware never re-enables [RL15] [RL7] [RL17]
    if (master_on && multi_mode && !ss_s2_reg) begin
      ctrl_next.master_enable_bit = 1'b0;
      ctrl_next.port_enable_bit = 1'b0;
      flags_next.mode_fault_flag = 1'b1;
      state_next = ST_IDLE;
      sck_next = 1'b0;
    end
    if (!master_on) begin
      state_next = ST_IDLE;
      sck_next = 1'b0;
    end
    mosi_next = shift_next[7]; // [RL1]
    mosi_oe_next = master_on;
    sck_oe_next = master_on;
    // Slave output only while selected [RL2] [RL3] [RL5] [RL6]
    miso_oe_next = slave_on & ((ctrl_reg.select_mode_field == MODE_3WIRE) | (multi_mode & ~ss_s2_reg));
    ss_oe_next = ctrl_reg.select_mode_field[MODE_UPPER_POS]; // [RL8]
    ss_out_next = ctrl_reg.select_mode_field[MODE_LOWER_POS]; // [RL8]
    routed_next = ctrl_reg.select_mode_field != MODE_3WIRE; // [RL9]
    clr_next = ~slave_on | (multi_mode & ss_s2_reg); // [RL4]
    irq_next = int_enable & (|flags_next); // [RL13] [RL16]
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_sys) begin
    ss_s1_reg <= slave_select_n_in;
    ss_s2_reg <= ss_s1_reg;
    miso_s1_reg <= miso_in;
    miso_s2_reg <= miso_s1_reg;
    done_s1_reg <= slv_done;
    done_s2_reg <= done_s1_reg;
    ack_s1_reg <= slv_ack;
    ack_s2_reg <= ack_s1_reg;
    if (reset) begin
      ctrl_reg <= CTRL_RESET; // [RL15]
      flags_reg <= FLAGS_RESET;
      state_reg <= ST_IDLE;
      tx_buf_reg <= 8'h00;
      tx_full_reg <= 1'b0;
      shift_reg <= 8'h00;
      samp_reg <= 1'b0;
      bit_reg <= 3'h0;
      div_reg <= 8'h00;
      rx_reg <= 8'h00;
      unread_reg <= 1'b0;
      irq_reg <= 1'b0;
      sck_reg <= 1'b0;
      mosi_reg <= 1'b0;
      mosi_oe_reg <= 1'b0;
      sck_oe_reg <= 1'b0;
      miso_oe_reg <= 1'b0;
      ss_out_reg <= 1'b0;
      ss_oe_reg <= 1'b0;
      routed_reg <= 1'b0;
      clr_reg <= 1'b1;
      req_reg <= 1'b0;
      slv_byte_reg <= 8'h00;
      done_last_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      flags_reg <= flags_next;
      state_reg <= state_next;
      tx_buf_reg <= tx_buf_next;
      tx_full_reg <= tx_full_next;
      shift_reg <= shift_next;
      samp_reg <= samp_next;
      bit_reg <= bit_next;
      div_reg <= div_next;
      rx_reg <= rx_next;
      unread_reg <= unread_next;
      irq_reg <= irq_next;
      sck_reg <= sck_next;
      mosi_reg <= mosi_next;
      mosi_oe_reg <= mosi_oe_next;
      sck_oe_reg <= sck_oe_next;
      miso_oe_reg <= miso_oe_next;
      ss_out_reg <= ss_out_next;
      ss_oe_reg <= ss_oe_next;
      routed_reg <= routed_next;
      clr_reg <= clr_next;
      req_reg <= req_next;
      slv_byte_reg <= slv_byte_next;
      done_last_reg <= done_last_next;
    end
  end

  assign ctrl_out = ctrl_reg;
  assign flags_out = flags_reg;
  assign rx_data = rx_reg;
  assign tx_buf_full = tx_full_reg;
  assign irq_req = irq_reg;
  assign sck_out = sck_reg;
  assign sck_oe = sck_oe_reg;
  assign mosi_out = mosi_reg;
  assign mosi_oe = mosi_oe_reg;
  assign miso_out = slv_miso;
  assign miso_oe = miso_oe_reg;
  assign slave_select_n_out = ss_out_reg;
  assign slave_select_n_oe = ss_oe_reg;
  assign select_routed = routed_reg;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_mosi_top_bit: assert property (state_reg != ST_IDLE |-> mosi_out == shift_reg[7]) // [RL1]
    else $error("master output not shift top bit");
  a_miso_float: assert property (!ctrl_reg.port_enable_bit |=> !miso_oe) // [RL2]
    else $error("slave output driven while disabled");
  a_miso_3wire: assert property (slave_on && ctrl_reg.select_mode_field == MODE_3WIRE |=> miso_oe) // [RL3]
    else $error("3-wire slave output not driven");
  a_mode_fault: assert property (master_on && multi_mode && !ss_s2_reg
    |=> !ctrl_reg.master_enable_bit && !ctrl_reg.port_enable_bit && flags_reg.mode_fault_flag) // [RL15]
    else $error("mode fault not handled");
  a_select_drive: assert property (ctrl_reg.select_mode_field[MODE_UPPER_POS] && !ctrl_wr
    |=> ##1 slave_select_n_oe && slave_select_n_out == $past(ctrl_reg.select_mode_field[MODE_LOWER_POS], 2)) // [RL8]
    else $error("select output wrong");
  a_select_route: assert property (ctrl_reg.select_mode_field == MODE_3WIRE |=> !select_routed) // [RL9]
    else $error("select routed in 3-wire mode");
  a_write_collide: assert property (data_wr && tx_full_reg && !start
    |=> flags_reg.write_collision_flag && tx_buf_reg == $past(tx_buf_reg)) // [RL18]
    else $error("collision not flagged");
  a_flag_sticky: assert property (flags_reg.transfer_complete_flag && !flag_clr.transfer_complete_flag
    |=> flags_reg.transfer_complete_flag) // [RL19]
    else $error("complete flag cleared by hardware");
  a_sck_rate: assert property ($rose(sck_out) |-> sck_out [*2]) // [RL20]
    else $error("serial clock high too short");
  a_start_now: assert property (state_reg == ST_IDLE && master_on && tx_full_reg && ss_s2_reg
    |=> state_reg == ST_LOW && !tx_full_reg) // [RL11]
    else $error("transfer did not start");
  a_byte_done: assert property (finishing && !(master_on && multi_mode && !ss_s2_reg)
    |=> flags_reg.transfer_complete_flag && rx_data == $past({shift_reg[6:0], samp_reg})) // [RL13]
    else $error("byte end not flagged");
  a_irq_follow: assert property (int_enable && flags_reg.mode_fault_flag && !flag_clr.mode_fault_flag && $stable(int_enable)
    |=> irq_req) // [RL16]
    else $error("interrupt request missing");

  c_master_byte: cover property (finishing);
  c_back_to_back: cover property (finishing && start);
  c_mode_fault: cover property ($rose(flags_reg.mode_fault_flag));
  c_slave_byte: cover property (!clr_reg && done_s2_reg != done_last_reg);

endmodule
`default_nettype wire

/* sms_peer_model.sv */
// Purpose: Far-side serial peer, slave to the core's master and master to its slave
// Assumes: Clock idles low, data sampled on the rise and changed on the fall
// Notes:   Link clock runs only inside frames; a released data line shows the inverse bit
`timescale 1ns/1ps
`default_nettype none
module sms_peer_model
  import sms_pkg::*;
(
  input wire logic sck_out,
  input wire logic mosi_out,
  input wire logic miso_out,
  input wire logic resp_load,
  input wire logic [15:0] resp_word,
  output logic miso_in,
  output logic [15:0] cap_hist,
  output logic sck_link,
  output logic mosi_in,
  output logic ss_n,
  output logic [7:0] link_rx
);
  logic [15:0] resp_sh;

  initial begin
    sck_link = 1'b0;
    mosi_in = 1'b0;
    ss_n = 1'b1;
    link_rx = 8'h00;
    cap_hist = 16'h0000;
    resp_sh = 16'h0000;
  end

  // ****************************************
  // Slave role
  // ****************************************
  assign miso_in = resp_sh[15];
  always @(posedge resp_load) begin
    resp_sh <= resp_word;
  end
  // New bit at the fall, so it settles through the core's synchroniser before the rise
  always @(negedge sck_out) begin
    resp_sh <= {resp_sh[14:0], ~resp_sh[15]};
  end
  always @(posedge sck_out) begin
    cap_hist <= {cap_hist[14:0], mosi_out};
  end

  // ****************************************
  // Master role
  // ****************************************
  task automatic set_sel(input logic sel);
    ss_n = ~sel;
  endtask

  task automatic frame(input logic sel, input logic [7:0] b);
    ss_n = ~sel;
    #200;
    for (int i = 7; i >= 0; i--) begin
      mosi_in = b[i];
      #62.5 sck_link = 1'b1;
      link_rx = {link_rx[6:0], miso_out};
      #62.5 sck_link = 1'b0;
    end
    #62.5 mosi_in = ~b[0];
    // Gap keeps the byte rate under a tenth of the system clock
    #200;
  endtask
endmodule
`default_nettype wire

/* sms_pkg.sv */
// Purpose: Shared constants and types for the select-mode serial port
// Assumes: System clock of 50 MHz
// Notes:   Mode encodings follow the two-bit select-mode field
package sms_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned MAX_BIT_HZ = 12_500_000;
  // Least half period of the generated clock, rounded up to whole cycles
  localparam int unsigned MIN_HALF_CYCLES = (CLK_HZ + 2 * MAX_BIT_HZ - 1) / (2 * MAX_BIT_HZ);
  localparam int unsigned BYTE_BITS = 8;

  // ****************************************
  // Select modes and control
  // ****************************************
  localparam logic [1:0] MODE_3WIRE = 2'h0;
  localparam logic [1:0] MODE_MULTI = 2'h1;
  localparam int unsigned MODE_UPPER_POS = 1;
  localparam int unsigned MODE_LOWER_POS = 0;

  typedef struct packed {
    logic master_enable_bit;
    logic port_enable_bit;
    logic [1:0] select_mode_field;
  } sms_ctrl_t;

  localparam sms_ctrl_t CTRL_RESET = '{master_enable_bit: 1'b0, port_enable_bit: 1'b0,
                                       select_mode_field: MODE_MULTI};

  typedef struct packed {
    logic transfer_complete_flag;
    logic write_collision_flag;
    logic mode_fault_flag;
    logic receive_overrun_flag;
  } sms_flags_t;

  localparam sms_flags_t FLAGS_RESET = '{default: 1'b0};

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOW  = 2'b01,
    ST_HIGH = 2'b10
  } sms_state_t;

endpackage

/* sms_slave_link.sv */
// Purpose: Slave-side shifter clocked by the incoming serial clock
// Assumes: Clock idles low, data sampled on the rising edge
// Notes:   Talks to the system side by toggles and held bytes only
`timescale 1ns/1ps
`default_nettype none
module sms_slave_link
  import sms_pkg::*;
(
  input wire logic sck_link,
  input wire logic link_clr,
  input wire logic mosi_in,
  input wire logic tx_req,
  input wire logic [7:0] tx_byte,
  output logic tx_ack,
  output logic done_tgl,
  output logic [7:0] rx_byte,
  output logic miso_out
);

  logic req_s1_reg, req_s2_reg;
  logic [7:0] shift_reg, shift_next;
  logic [2:0] cnt_reg, cnt_next;
  logic ack_reg, ack_next;
  logic done_reg, done_next;
  logic [7:0] rx_reg, rx_next;
  logic [7:0] sampled;

  // ****************************************
  // Shift path
  // ****************************************
  always_comb begin
    sampled = {shift_reg[6:0], mosi_in};
    shift_next = sampled;
    cnt_next = cnt_reg + 3'h1;
    ack_next = ack_reg;
    done_next = done_reg;
    rx_next = rx_reg;
    if (cnt_reg == 3'(BYTE_BITS - 1)) begin
      rx_next = sampled;
      done_next = ~done_reg;
      // Next byte is loaded after the last edge so its first bit is ready in time
      if (req_s2_reg != ack_reg) begin
        shift_next = tx_byte;
        ack_next = ~ack_reg;
      end
    end
  end

  // Held in clear while deselected or disabled, so clock edges are ignored [RL4]
  always_ff @(posedge sck_link or posedge link_clr) begin
    if (link_clr) begin
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
      shift_reg <= 8'h00;
      cnt_reg <= 3'h0;
      ack_reg <= 1'b0;
      done_reg <= 1'b0;
      rx_reg <= 8'h00;
    end else begin
      req_s1_reg <= tx_req;
      req_s2_reg <= req_s1_reg;
      shift_reg <= shift_next;
      cnt_reg <= cnt_next;
      ack_reg <= ack_next;
      done_reg <= done_next;
      rx_reg <= rx_next;
    end
  end

  assign tx_ack = ack_reg;
  assign done_tgl = done_reg;
  assign rx_byte = rx_reg;
  assign miso_out = shift_reg[7]; // [RL3]

endmodule
`default_nettype wire

/* test_spi_master_slave_select_core.sv */
// Purpose: Self-checking bench for the select-mode serial port
// Assumes: Default half period of four system clocks
// Notes:   Select wire resolves the core's drive against the peer's
`timescale 1ns/1ps
`default_nettype none
module test_spi_master_slave_select_core
  import sms_pkg::*;
;
  logic clk_sys, reset, ctrl_wr, int_enable, data_wr, data_rd, resp_load;
  sms_ctrl_t ctrl_in, ctrl_out;
  sms_flags_t flag_clr, flags_out;
  logic [7:0] data_in, rx_data, link_rx;
  logic [15:0] resp_word, cap_hist;
  logic tx_buf_full, irq_req, sck_out, sck_oe, mosi_out, mosi_oe, mosi_in, miso_out, miso_oe, miso_in;
  logic sck_link, ss_out, ss_oe, select_routed, peer_ss_n, ss_wire;
  int err_count, checks_done;

  assign ss_wire = ss_oe ? ss_out : peer_ss_n;

  sms_core #(.SCK_HALF_CYCLES(4)) i_sms_core (.clk_sys(clk_sys), .reset(reset), .sck_link(sck_link),
    .ctrl_wr(ctrl_wr), .ctrl_in(ctrl_in), .int_enable(int_enable), .data_wr(data_wr), .data_in(data_in),
    .data_rd(data_rd), .flag_clr(flag_clr), .ctrl_out(ctrl_out), .flags_out(flags_out), .rx_data(rx_data),
    .tx_buf_full(tx_buf_full), .irq_req(irq_req), .sck_out(sck_out), .sck_oe(sck_oe), .mosi_out(mosi_out),
    .mosi_oe(mosi_oe), .mosi_in(mosi_in), .miso_out(miso_out), .miso_oe(miso_oe), .miso_in(miso_in),
    .slave_select_n_in(ss_wire), .slave_select_n_out(ss_out), .slave_select_n_oe(ss_oe),
    .select_routed(select_routed));

  sms_peer_model i_sms_peer_model (.sck_out(sck_out), .mosi_out(mosi_out), .miso_out(miso_out),
    .resp_load(resp_load), .resp_word(resp_word), .miso_in(miso_in), .cap_hist(cap_hist),
    .sck_link(sck_link), .mosi_in(mosi_in), .ss_n(peer_ss_n), .link_rx(link_rx));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk1(input string name, input logic exp, input logic got);
    chk8(name, {7'h00, exp}, {7'h00, got});
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic ctrl_write(input logic me, input logic pe, input logic [1:0] md);
    @(posedge clk_sys);
    ctrl_wr <= 1'b1;
    ctrl_in <= '{master_enable_bit: me, port_enable_bit: pe, select_mode_field: md};
    @(posedge clk_sys);
    ctrl_wr <= 1'b0;
    cycles(2);
  endtask

  task automatic wr(input logic [7:0] b);
    @(posedge clk_sys);
    data_wr <= 1'b1;
    data_in <= b;
    @(posedge clk_sys);
    data_wr <= 1'b0;
  endtask

  task automatic pulse_clr();
    @(posedge clk_sys);
    flag_clr <= '{default: 1'b1};
    data_rd <= 1'b1;
    @(posedge clk_sys);
    flag_clr <= '{default: 1'b0};
    data_rd <= 1'b0;
    cycles(1);
  endtask

  // Bounded wait on the complete flag (0) or the fault flag (1)
  task automatic wait_on(input int which);
    int n;
    n = 0;
    while (n < 2000) begin
      cycles(1);
      if (which == 0 && flags_out.transfer_complete_flag === 1'b1) break;
      if (which == 1 && flags_out.mode_fault_flag === 1'b1) break;
      n++;
    end
    if (n >= 2000) begin
      err_count++;
      $display("unexpected timeout on flag %0d", which);
      conclude();
    end
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    reset = 1'b1;
    ctrl_wr = 1'b0;
    ctrl_in = '{default: 1'b0};
    int_enable = 1'b0;
    data_wr = 1'b0;
    data_in = 8'h00;
    data_rd = 1'b0;
    flag_clr = '{default: 1'b0};
    resp_load = 1'b0;
    resp_word = 16'h3CE1;
    err_count = 0;
    checks_done = 0;
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    cycles(2);
    chk8("ctrl_out", 8'h01, {4'h0, ctrl_out});
    chk8("flags_out", 8'h00, {4'h0, flags_out});
    chk1("select_routed", 1'b1, select_routed);
    chk1("miso_oe", 1'b0, miso_oe);
    $display("test reset done");

    ctrl_write(1'b1, 1'b1, 2'h0);
    chk1("select_routed", 1'b0, select_routed);
    chk1("mosi_oe", 1'b1, mosi_oe);
    chk1("sck_oe", 1'b1, sck_oe);
    @(posedge clk_sys);
    resp_load <= 1'b1;
    @(posedge clk_sys);
    resp_load <= 1'b0;
    wr(8'hA5);
    cycles(3);
    chk1("tx_buf_full", 1'b0, tx_buf_full);
    wr(8'h5A);
    wr(8'hFF);
    wait_on(0);
    chk8("rx_data", 8'h3C, rx_data);
    chk1("write_collision", 1'b1, flags_out.write_collision_flag);
    chk1("irq_req", 1'b0, irq_req);
    @(posedge clk_sys);
    int_enable <= 1'b1;
    cycles(2);
    chk1("irq_req", 1'b1, irq_req);
    pulse_clr();
    wait_on(0);
    chk8("rx_data", 8'hE1, rx_data);
    cycles(20);
    chk8("sent first", 8'hA5, cap_hist[15:8]);
    chk8("sent second", 8'h5A, cap_hist[7:0]);
    chk1("write_collision", 1'b0, flags_out.write_collision_flag);
    chk1("complete", 1'b1, flags_out.transfer_complete_flag);
    pulse_clr();
    chk8("flags_out", 8'h00, {4'h0, flags_out});
    $display("test master done");

    for (int md = 2; md < 4; md++) begin
      ctrl_write(1'b1, 1'b1, md[1:0]);
      chk1("ss_oe", 1'b1, ss_oe);
      chk1("ss_out", md[0], ss_out);
      chk1("select_routed", 1'b1, select_routed);
    end
    $display("test select output done");

    ctrl_write(1'b1, 1'b1, 2'h1);
    chk1("ss_oe", 1'b0, ss_oe);
    chk8("ctrl_out", 8'h0D, {4'h0, ctrl_out});
    i_sms_peer_model.set_sel(1'b1);
    wait_on(1);
    chk8("ctrl_out", 8'h01, {4'h0, ctrl_out});
    chk1("irq_req", 1'b1, irq_req);
    cycles(20);
    chk8("ctrl_out", 8'h01, {4'h0, ctrl_out});
    chk1("mosi_oe", 1'b0, mosi_oe);
    pulse_clr();
    $display("test mode fault done");

    ctrl_write(1'b0, 1'b1, 2'h1);
    cycles(4);
    chk1("miso_oe", 1'b1, miso_oe);
    i_sms_peer_model.frame(1'b1, 8'h96);
    wait_on(0);
    chk8("rx_data", 8'h96, rx_data);
    pulse_clr();
    i_sms_peer_model.set_sel(1'b0);
    cycles(6);
    chk1("miso_oe", 1'b0, miso_oe);
    i_sms_peer_model.frame(1'b0, 8'h11);
    cycles(10);
    chk1("complete", 1'b0, flags_out.transfer_complete_flag);
    i_sms_peer_model.set_sel(1'b1);
    ctrl_write(1'b0, 1'b0, 2'h1);
    cycles(4);
    chk1("miso_oe", 1'b0, miso_oe);
    $display("test slave select done");

    i_sms_peer_model.set_sel(1'b0);
    ctrl_write(1'b0, 1'b1, 2'h0);
    cycles(4);
    chk1("miso_oe", 1'b1, miso_oe);
    wr(8'h5B);
    i_sms_peer_model.frame(1'b0, 8'hC3);
    wait_on(0);
    chk8("rx_data", 8'hC3, rx_data);
    i_sms_peer_model.frame(1'b0, 8'h00);
    chk8("slave sent", 8'h5B, link_rx);
    chk1("overrun", 1'b1, flags_out.receive_overrun_flag);
    chk8("rx_data", 8'hC3, rx_data);
    $display("test three wire slave done");
    conclude();
  end
endmodule
`default_nettype wire
